// *** bbpp_cfg.svh ***
// Constants for the bit-bang parallel port
`ifndef BBPP_CFG_SVH
`define BBPP_CFG_SVH
`define BBPP_MODE_RESET 8'h00
`define BBPP_MODE_ASYNC 8'h01
`define BBPP_MODE_SYNC 8'h04
`define BBPP_DIR_RESET 8'h00
`define BBPP_OUT_RESET 8'h00
`define BBPP_PRI_FIFO 2'h0
`define BBPP_PRI_OPTO 2'h1
`define BBPP_PRI_UART 2'h2
`define BBPP_MAX_BAUD_HZ 1000000
`define BBPP_BAUD_DIV_DEF 16'h000F
`define BBPP_WAKE_PULSE 2'h2
`endif

// *** bbpp_pkg.sv ***
// Types for the bit-bang parallel port
package bbpp_pkg;
  typedef enum logic [2:0]
  {
    BBPP_IDLE = 3'b000,
    BBPP_SAMPLE = 3'b001,
    BBPP_RD_OFF = 3'b010,
    BBPP_DRIVE = 3'b011,
    BBPP_SETUP = 3'b100,
    BBPP_WR_ON = 3'b101,
    BBPP_WR_OFF = 3'b110
  } bbpp_state_t;
endpackage

// *** bbpp_if.sv ***
// Pin-level link between the port and the external logic
`timescale 1ns/1ns
interface bbpp_if;
  logic [7:0] bus_dev_o;
  logic [7:0] bus_dev_oe;
  logic [7:0] bus_ext_o;
  logic [7:0] bus_ext_oe;
  logic [7:0] bus_level;
  logic status_wr_n;
  logic status_rd_n;
  logic strobe_wr_n;
  logic strobe_rd_n;
  logic flush_or_wake_in_n;
  logic power_enable_n;
  integer k;
  always_comb
  begin
    for (k = 0; k < 8; k = k + 1)
    begin
      if (bus_dev_oe[k])
        bus_level[k] = bus_dev_o[k];
      else if (bus_ext_oe[k])
        bus_level[k] = bus_ext_o[k];
      else
        bus_level[k] = 1'b1;
    end
  end
  modport dev
  (
    output bus_dev_o, bus_dev_oe, status_wr_n, status_rd_n, strobe_wr_n, strobe_rd_n,
    output power_enable_n,
    input bus_level, flush_or_wake_in_n
  );
  modport ext
  (
    output bus_ext_o, bus_ext_oe, flush_or_wake_in_n,
    input bus_level, status_wr_n, status_rd_n, strobe_wr_n, strobe_rd_n, power_enable_n
  );
endinterface

// *** bbpp_ext.sv ***
// External logic end that samples the pin-bus strobes on clock_i
`timescale 1ns/1ns
`include "bbpp_cfg.svh"
module bbpp_ext
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  bbpp_if.ext pins,
  input wire logic [7:0] drive_val_i,
  input wire logic [7:0] drive_en_i,
  input wire logic use_uart_pins_i,
  input wire logic flush_or_wake_req_i,
  output logic [7:0] wr_capture_o,
  output logic wr_seen_o,
  output logic rd_seen_o,
  output logic power_enable_n_o
);
  logic wr_prev;
  logic rd_prev;
  logic wr_now;
  logic rd_now;
  logic [1:0] pulse_cnt;
  assign wr_now = use_uart_pins_i ? pins.strobe_wr_n : pins.status_wr_n;
  assign rd_now = use_uart_pins_i ? pins.strobe_rd_n : pins.status_rd_n;
  // Bus drive towards the device pins
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      pins.bus_ext_o <= 8'h00;
      pins.bus_ext_oe <= 8'h00;
    end
    else
    begin
      pins.bus_ext_o <= drive_val_i;
      pins.bus_ext_oe <= drive_en_i;
    end
  end
  // Strobe edge detection on clock_i, bus captured on each write
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
      wr_capture_o <= 8'h00;
      wr_seen_o <= 1'b0;
      rd_seen_o <= 1'b0;
      power_enable_n_o <= 1'b1;
    end
    else
    begin
      wr_prev <= wr_now;
      rd_prev <= rd_now;
      wr_seen_o <= wr_now && !wr_prev;
      rd_seen_o <= rd_now && !rd_prev;
      power_enable_n_o <= pins.power_enable_n;
      if (wr_now && !wr_prev)
        wr_capture_o <= pins.bus_level;
    end
  end
  // Low pulse of two cycles on the flush or wake pin
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      pulse_cnt <= 2'h0;
    else if (flush_or_wake_req_i && pulse_cnt == 2'h0)
      pulse_cnt <= `BBPP_WAKE_PULSE;
    else if (pulse_cnt != 2'h0)
      pulse_cnt <= pulse_cnt - 2'h1;
  end
  assign pins.flush_or_wake_in_n = (pulse_cnt == 2'h0);
endmodule

// *** bbpp_dev.sv ***
// Device end of the bit-bang parallel port for one channel
`timescale 1ns/1ns
`include "bbpp_cfg.svh"
module bbpp_dev
#(
  parameter bit IS_CHAN_B = 1'b0,
  parameter logic [15:0] BAUD_DIV = `BBPP_BAUD_DIV_DEF
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  bbpp_if.dev pins,
  input wire logic [7:0] mode_i,
  input wire logic mode_load_i,
  input wire logic [7:0] dir_i,
  input wire logic dir_load_i,
  input wire logic [1:0] primary_mode_i,
  input wire logic suspend_i,
  input wire logic wake_enable_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic resume_req_o,
  output logic flush_req_o,
  output logic [7:0] mode_o
);
  bbpp_pkg::bbpp_state_t state;
  logic [15:0] baud_cnt;
  logic tick;
  logic [7:0] dir;
  logic [7:0] out_val;
  logic [7:0] pend;
  logic pend_ok;
  logic rd_n;
  logic wr_n;
  logic fw_prev;
  logic active;
  logic is_async;
  logic is_sync;
  logic use_uart;
  logic next_bb;
  // Opto mode on channel B blocks bit-bang
  assign next_bb = !(IS_CHAN_B && primary_mode_i == `BBPP_PRI_OPTO);
  assign is_async = (mode_o == `BBPP_MODE_ASYNC);
  assign is_sync = (mode_o == `BBPP_MODE_SYNC);
  assign active = is_async || is_sync;
  assign use_uart = (primary_mode_i == `BBPP_PRI_UART);
  // Mode select
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      mode_o <= `BBPP_MODE_RESET;
    else if (mode_load_i)
    begin
      if ((mode_i == `BBPP_MODE_ASYNC || mode_i == `BBPP_MODE_SYNC) && next_bb)
        mode_o <= mode_i;
      else
        mode_o <= `BBPP_MODE_RESET;
    end
  end
  // Per-pin direction
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      dir <= `BBPP_DIR_RESET;
    else if (dir_load_i)
      dir <= dir_i;
  end
  // Baud tick divider
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || !active)
      baud_cnt <= 16'h0000;
    else if (baud_cnt >= BAUD_DIV)
      baud_cnt <= 16'h0000;
    else
      baud_cnt <= baud_cnt + 16'h0001;
  end
  assign tick = active && (baud_cnt >= BAUD_DIV);
  // Byte intake, one held at a time
  assign tx_ready_o = active && !pend_ok;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || !active)
    begin
      pend <= 8'h00;
      pend_ok <= 1'b0;
    end
    else if (tx_valid_i && !pend_ok)
    begin
      pend <= tx_data_i;
      pend_ok <= 1'b1;
    end
    else if (is_async && tick && state == bbpp_pkg::BBPP_IDLE)
      pend_ok <= 1'b0;
    else if (is_sync && state == bbpp_pkg::BBPP_DRIVE)
      pend_ok <= 1'b0;
  end
  // Access sequencer and output latch
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state <= bbpp_pkg::BBPP_IDLE;
      out_val <= `BBPP_OUT_RESET;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
    end
    else
    begin
      if (rx_valid_o && rx_ready_i)
        rx_valid_o <= 1'b0;
      case (state)
        bbpp_pkg::BBPP_IDLE:
        begin
          rd_n <= 1'b1;
          wr_n <= 1'b1;
          if (is_async && pend_ok && tick)
          begin
            out_val <= pend;
            wr_n <= 1'b0;
            state <= bbpp_pkg::BBPP_WR_OFF;
          end
          else if (is_sync && pend_ok && tick && !rx_valid_o)
          begin
            rd_n <= 1'b0;
            state <= bbpp_pkg::BBPP_SAMPLE;
          end
        end
        bbpp_pkg::BBPP_SAMPLE:
        begin
          rx_data_o <= pins.bus_level;
          rx_valid_o <= 1'b1;
          state <= bbpp_pkg::BBPP_RD_OFF;
        end
        bbpp_pkg::BBPP_RD_OFF:
        begin
          rd_n <= 1'b1;
          state <= bbpp_pkg::BBPP_DRIVE;
        end
        bbpp_pkg::BBPP_DRIVE:
        begin
          rd_n <= 1'b0;
          out_val <= pend;
          state <= bbpp_pkg::BBPP_SETUP;
        end
        bbpp_pkg::BBPP_SETUP:
          state <= bbpp_pkg::BBPP_WR_ON;
        bbpp_pkg::BBPP_WR_ON:
        begin
          wr_n <= 1'b0;
          state <= bbpp_pkg::BBPP_WR_OFF;
        end
        bbpp_pkg::BBPP_WR_OFF:
        begin
          wr_n <= 1'b1;
          rd_n <= 1'b1;
          state <= bbpp_pkg::BBPP_IDLE;
        end
        default:
          state <= bbpp_pkg::BBPP_IDLE;
      endcase
      if (!active)
        state <= bbpp_pkg::BBPP_IDLE;
    end
  end
  // Pin drive and strobe routing
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      pins.bus_dev_o <= `BBPP_OUT_RESET;
      pins.bus_dev_oe <= 8'h00;
      pins.status_wr_n <= 1'b1;
      pins.status_rd_n <= 1'b1;
      pins.strobe_wr_n <= 1'b1;
      pins.strobe_rd_n <= 1'b1;
      pins.power_enable_n <= 1'b1;
    end
    else
    begin
      pins.bus_dev_o <= out_val;
      pins.bus_dev_oe <= active ? dir : 8'h00;
      pins.status_wr_n <= (active && !use_uart) ? wr_n : 1'b1;
      pins.status_rd_n <= (active && !use_uart) ? rd_n : 1'b1;
      pins.strobe_wr_n <= (active && use_uart) ? wr_n : 1'b1;
      pins.strobe_rd_n <= (active && use_uart) ? rd_n : 1'b1;
      pins.power_enable_n <= suspend_i;
    end
  end
  // Flush or wake pulse detection
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      fw_prev <= 1'b1;
      resume_req_o <= 1'b0;
      flush_req_o <= 1'b0;
    end
    else
    begin
      fw_prev <= pins.flush_or_wake_in_n;
      resume_req_o <= fw_prev && !pins.flush_or_wake_in_n && suspend_i && wake_enable_i;
      flush_req_o <= fw_prev && !pins.flush_or_wake_in_n && !suspend_i;
    end
  end
endmodule

// *** bbpp_props.sv ***
// Assertions on the pin link of the bit-bang port
`timescale 1ns/1ns
module bbpp_props
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] bus_dev_o,
  input wire logic [7:0] bus_dev_oe,
  input wire logic status_wr_n,
  input wire logic status_rd_n,
  input wire logic strobe_wr_n,
  input wire logic strobe_rd_n
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  a_reset_idle: assert property ($rose(rst_n_i) |-> bus_dev_oe == 8'h00
    && (&{status_wr_n, status_rd_n, strobe_wr_n, strobe_rd_n}))
    else $error("pins not idle after reset");
  a_wr_one_cycle: assert property ($fell(status_wr_n) |=> status_wr_n)
    else $error("write strobe not one cycle");
  a_uart_wr_one: assert property ($fell(strobe_wr_n) |=> strobe_wr_n)
    else $error("uart pin write strobe not one cycle");
  a_status_alone: assert property (!(status_wr_n && status_rd_n) |->
    strobe_wr_n && strobe_rd_n)
    else $error("both strobe pairs active");
  a_uart_alone: assert property (!(strobe_wr_n && strobe_rd_n) |->
    status_wr_n && status_rd_n)
    else $error("both strobe pairs active");
  a_rd_bounded: assert property ($fell(status_rd_n) |-> ##[1:8] status_rd_n)
    else $error("read strobe stuck low");
  a_wr_inside_rd: assert property ($fell(status_wr_n) |-> !status_rd_n)
    else $error("write strobe outside read strobe");
  a_data_held: assert property ($rose(status_wr_n) || $rose(strobe_wr_n) |->
    $stable(bus_dev_o))
    else $error("data moved at write strobe end");
  c_sync_write: cover property ($fell(status_wr_n));
  c_uart_write: cover property ($fell(strobe_wr_n));
  c_read_strobe: cover property ($fell(status_rd_n));
endmodule

// *** bbpp_tb_top.sv ***
// Testbench for both ends of the bit-bang port
`timescale 1ns/1ns
module bbpp_tb_top;
  logic clk, rst_n, mld, dld, susp, wken, txv, rxr, uart, fw, txr, rxv, rsq, flq, hf, hr;
  logic [7:0] md, dir, txd, dval, den, rxd, mdq, cap, c;
  logic [1:0] prim;
  logic [7:0] mdb;
  logic wseen, rseen, pwn;
  logic [39:0] rows [6] = '{40'h00000055FF, 40'hFF0000AA55, 40'hFF0000AAAA,
    40'h0FF0A003AA, 40'h0FF0A003A3, 40'h00FF5CFF5C};
  logic [7:0] codes [4] = '{8'h01, 8'h04, 8'h02, 8'h00};
  int k;
  int n_mismatch = 0;
  int check_count = 0;
  int n_wr = 0;
  int n_rd = 0;
  bbpp_if bbpp_if_i();
  bbpp_dev #(.BAUD_DIV(16'h000A)) bbpp_dev_i
  (
    .clock_i(clk), .rst_n_i(rst_n), .pins(bbpp_if_i.dev), .mode_i(md), .mode_load_i(mld),
    .dir_i(dir), .dir_load_i(dld), .primary_mode_i(prim), .suspend_i(susp),
    .wake_enable_i(wken), .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr),
    .rx_data_o(rxd), .rx_valid_o(rxv), .rx_ready_i(rxr), .resume_req_o(rsq),
    .flush_req_o(flq), .mode_o(mdq)
  );
  bbpp_ext bbpp_ext_i
  (
    .clock_i(clk), .rst_n_i(rst_n), .pins(bbpp_if_i.ext), .drive_val_i(dval),
    .drive_en_i(den), .use_uart_pins_i(uart), .flush_or_wake_req_i(fw),
    .wr_capture_o(cap), .wr_seen_o(wseen), .rd_seen_o(rseen), .power_enable_n_o(pwn)
  );
  bbpp_props bbpp_props_i
  (
    .clock_i(clk), .rst_n_i(rst_n), .bus_dev_o(bbpp_if_i.bus_dev_o),
    .bus_dev_oe(bbpp_if_i.bus_dev_oe), .status_wr_n(bbpp_if_i.status_wr_n),
    .status_rd_n(bbpp_if_i.status_rd_n), .strobe_wr_n(bbpp_if_i.strobe_wr_n),
    .strobe_rd_n(bbpp_if_i.strobe_rd_n)
  );
  bbpp_if bbpp_if_b();
  assign bbpp_if_b.bus_ext_o = 8'h00;
  assign bbpp_if_b.bus_ext_oe = 8'h00;
  assign bbpp_if_b.flush_or_wake_in_n = 1'b1;
  bbpp_dev #(.IS_CHAN_B(1'b1), .BAUD_DIV(16'h000A)) bbpp_dev_b_i
  (
    .clock_i(clk), .rst_n_i(rst_n), .pins(bbpp_if_b.dev), .mode_i(md), .mode_load_i(mld),
    .dir_i(8'h00), .dir_load_i(1'b0), .primary_mode_i(prim), .suspend_i(1'b0),
    .wake_enable_i(1'b0), .tx_data_i(8'h00), .tx_valid_i(1'b0), .tx_ready_o(),
    .rx_data_o(), .rx_valid_o(), .rx_ready_i(1'b0), .resume_req_o(),
    .flush_req_o(), .mode_o(mdb)
  );
  always @(posedge clk)
  begin
    n_wr <= n_wr + int'(wseen);
    n_rd <= n_rd + int'(rseen);
  end
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send();
    txv = 1'b1;
    for (int i = 0; i < 99 && txr !== 1'b1; i++)
      tick(1);
    tick(1);
    txv = 1'b0;
  endtask
  task automatic take(input logic [7:0] e);
    for (int i = 0; i < 99 && rxv !== 1'b1; i++)
      tick(1);
    chk(rxd, e);
    rxr = 1'b1;
    tick(1);
    rxr = 1'b0;
  endtask
  task automatic set_mode(input logic [7:0] m);
    md = m;
    mld = 1'b1;
    tick(1);
    mld = 1'b0;
    tick(1);
  endtask
  task automatic load_dir();
    dld = 1'b1;
    tick(1);
    dld = 1'b0;
    tick(3);
  endtask
  task automatic poke();
    fw = 1'b1;
    tick(1);
    fw = 1'b0;
    hf = 1'b0;
    hr = 1'b0;
    repeat (12)
    begin
      tick(1);
      hf = hf | flq;
      hr = hr | rsq;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #500000;
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    {rst_n, mld, dld, susp, wken, txv, rxr, uart, fw} = 9'h000;
    {md, dir, txd, dval, den} = 40'h0000000000;
    prim = 2'h0;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick(1);
    chk(mdq, 8'h00);
    chk({7'h00, txr}, 8'h00);
    $display("reset test done");
    for (k = 0; k < 4; k++)
    begin
      set_mode(codes[k]);
      chk(mdq, (codes[k] == 8'h02) ? 8'h00 : codes[k]);
      chk(mdb, (codes[k] == 8'h02) ? 8'h00 : codes[k]);
    end
    prim = 2'h1;
    set_mode(8'h01);
    chk(mdq, 8'h01);
    chk(mdb, 8'h00);
    prim = 2'h0;
    $display("mode test done");
    set_mode(8'h04);
    for (k = 0; k < 6; k++)
    begin
      {dir, den, dval, txd, c} = rows[k];
      load_dir();
      send();
      take(c);
      tick(8);
      chk(cap, (txd & dir) | (~dir & (dval | ~den)));
    end
    chk(8'(n_wr), 8'h06);
    chk(8'(n_rd), 8'h0C);
    $display("sync test done");
    set_mode(8'h00);
    prim = 2'h2;
    uart = 1'b1;
    set_mode(8'h01);
    {dir, den} = 16'hFF00;
    load_dir();
    txd = 8'h3C;
    send();
    tick(16);
    chk(cap, 8'h3C);
    tick(30);
    chk(bbpp_if_i.bus_level, 8'h3C);
    chk(8'(n_wr), 8'h07);
    $display("async test done");
    poke();
    chk({6'h00, hr, hf}, 8'h01);
    chk({7'h00, pwn}, 8'h00);
    susp = 1'b1;
    wken = 1'b1;
    poke();
    chk({6'h00, hr, hf}, 8'h02);
    chk({7'h00, pwn}, 8'h01);
    $display("flush test done");
    finish_test();
  end
endmodule
